// ===== hdl/uart_test_inject_modem_status.sv
// error injection test register and handshake line status with interrupt
//
// Notes on behaviour
// - crc test bit corrupts fast infrared crc
// - chip test bit sends invalid pulse chips
// - baud test bit speeds rate generator
// - frame test bit sends zero stop bit
// - parity test bit inverts serial parity
// - bit 7 is inverted carrier detect pin
// - bit 3 flags carrier detect change
// - carrier detect never touches the receiver
// - bit 6 is inverted ring pin
// - bit 2 flags ring pin rising only
// - bit 5 is inverted data set ready
// - bit 1 flags data set ready change
// - all three lines raise the interrupt
// - status at 0x18, zero after reset
`timescale 1ns/1ps
module uart_test_inject_modem_status
    import uart_tims_pkg::*;
#(
    parameter int DIV_WIDTH = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire reg_req_t regReq,
    output logic [7:0] regRdData,
    input wire handshake_in_t handshakeIn,
    input wire logic fastInfraredMode,
    input wire tx_fields_t txIn,
    output tx_line_t txOut,
    input wire logic [DIV_WIDTH-1:0] baudDivisor,
    output logic baudTick,
    output logic irq
);
    logic [TEST_USED-1:0] testReg_q;
    logic [2:0] pinPrev_q;
    logic cdChange_q, riRise_q, dsrChange_q;
    logic [2:0] irqStatus_q, irqMask_q;
    logic [DIV_WIDTH-1:0] baudCount_q;
    logic baudTick_q;
    logic [7:0] rdData_q;
    tx_line_t txOut_q;
    logic testWrite, statusRead, irqStatusWrite, irqMaskWrite;
    logic cdEdge, riEdge, dsrEdge;
    logic [2:0] pinNow;
    logic [7:0] statusValue;

    // address decode
    always_comb begin
        testWrite = 1'b0;
        statusRead = 1'b0;
        irqStatusWrite = 1'b0;
        irqMaskWrite = 1'b0;
        if (regReq.addr == TEST_OFFSET) begin
            testWrite = regReq.write;
        end else if (regReq.addr == STATUS_OFFSET) begin
            statusRead = regReq.read;
        end else if (regReq.addr == IRQ_STATUS_OFFSET) begin
            irqStatusWrite = regReq.write;
        end else if (regReq.addr == IRQ_MASK_OFFSET) begin
            irqMaskWrite = regReq.write;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            testReg_q <= TEST_RESET[TEST_USED-1:0];
        end else if (testWrite) begin
            testReg_q <= regReq.wrData[TEST_USED-1:0];
        end
    end

    // line inputs are already synchronous; one stage keeps the last level
    assign pinNow = {handshakeIn.carrierDetect_n, handshakeIn.ringIndicator_n,
                     handshakeIn.dataSetReady_n};

    // pins taken at reset release so a line held low raises no false change
    logic armed_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
            pinPrev_q <= 3'h7;
        end else begin
            armed_q <= 1'b1;
            pinPrev_q <= pinNow;
        end
    end

    assign cdEdge = armed_q & (pinNow[2] ^ pinPrev_q[2]);
    assign riEdge = armed_q & pinNow[1] & ~pinPrev_q[1];
    assign dsrEdge = armed_q & (pinNow[0] ^ pinPrev_q[0]);

    // read clears flags; a same-cycle edge wins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cdChange_q <= STATUS_RESET[CD_CHANGE_BIT];
            riRise_q <= STATUS_RESET[RI_RISE_BIT];
            dsrChange_q <= STATUS_RESET[DSR_CHANGE_BIT];
        end else begin
            cdChange_q <= cdEdge | (cdChange_q & ~statusRead);
            riRise_q <= riEdge | (riRise_q & ~statusRead);
            dsrChange_q <= dsrEdge | (dsrChange_q & ~statusRead);
        end
    end

    always_comb begin
        statusValue = STATUS_RESET;
        statusValue[CD_LEVEL_BIT] = armed_q & ~pinNow[2];
        statusValue[RI_LEVEL_BIT] = armed_q & ~pinNow[1];
        statusValue[DSR_LEVEL_BIT] = armed_q & ~pinNow[0];
        statusValue[CD_CHANGE_BIT] = cdChange_q;
        statusValue[RI_RISE_BIT] = riRise_q;
        statusValue[DSR_CHANGE_BIT] = dsrChange_q;
    end

    // every line sets a sticky interrupt bit, set beats clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus_q <= IRQ_RESET;
        end else begin
            irqStatus_q <= (irqStatus_q & ~({3{irqStatusWrite}} & regReq.wrData[2:0]))
                | {dsrEdge, riEdge, cdEdge};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqMask_q <= IRQ_RESET;
        end else if (irqMaskWrite) begin
            irqMask_q <= regReq.wrData[2:0];
        end
    end

    assign irq = |(irqStatus_q & irqMask_q);

    // read port; test register is write only and reads zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= READ_ZERO;
        end else if (!regReq.read) begin
            rdData_q <= READ_ZERO;
        end else if (regReq.addr == STATUS_OFFSET) begin
            rdData_q <= statusValue;
        end else if (regReq.addr == IRQ_STATUS_OFFSET) begin
            rdData_q <= {5'h00, irqStatus_q};
        end else if (regReq.addr == IRQ_MASK_OFFSET) begin
            rdData_q <= {5'h00, irqMask_q};
        end else begin
            rdData_q <= READ_ZERO;
        end
    end

    assign regRdData = rdData_q;

    // carrier detect reaches only the status and interrupt paths, no receiver gating
    // fast test ticks every cycle; divisor zero also ticks every cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            baudCount_q <= '0;
            baudTick_q <= 1'b0;
        end else if (testReg_q[BAUD_BIT] || baudCount_q + 1'b1 >= baudDivisor) begin
            baudCount_q <= '0;
            baudTick_q <= 1'b1;
        end else begin
            baudCount_q <= baudCount_q + 1'b1;
            baudTick_q <= 1'b0;
        end
    end

    assign baudTick = baudTick_q;

    // corruption is applied only in the mode each test targets
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            txOut_q <= '{parityBit: 1'b0, stopBit: 1'b1, chipCode: 4'h1, crc: 16'h0000};
        end else begin
            txOut_q.parityBit <= txIn.parityBit
                ^ (testReg_q[PARITY_BIT] & ~fastInfraredMode);
            // zero stop bit in serial mode
            txOut_q.stopBit <= ~(testReg_q[STOP_BIT] & ~fastInfraredMode);
            // no-pulse chip is never a valid slot code
            txOut_q.chipCode <= (testReg_q[CHIP_BIT] & fastInfraredMode) ? BAD_CHIP : txIn.chipCode;
            txOut_q.crc <= txIn.crc ^ {16{testReg_q[CRC_BIT] & fastInfraredMode}};
        end
    end

    assign txOut = txOut_q;

    // checks
    logic riFall;
    assign riFall = armed_q & ~pinNow[1] & pinPrev_q[1];

    chk_parity_inject: assert property (@(posedge clock) disable iff (!reset_n)
        testReg_q[PARITY_BIT] && !fastInfraredMode |=> txOut.parityBit != $past(txIn.parityBit))
        else $error("parity not inverted under test");
    chk_stop_zero: assert property (@(posedge clock) disable iff (!reset_n)
        !fastInfraredMode |=> txOut.stopBit == !$past(testReg_q[STOP_BIT]))
        else $error("stop bit value wrong");
    chk_crc_corrupt: assert property (@(posedge clock) disable iff (!reset_n)
        testReg_q[CRC_BIT] && fastInfraredMode |=> txOut.crc == ~$past(txIn.crc))
        else $error("crc not corrupted");
    chk_chip_invalid: assert property (@(posedge clock) disable iff (!reset_n)
        testReg_q[CHIP_BIT] && fastInfraredMode |=> !$onehot(txOut.chipCode))
        else $error("valid chip sent under test");
    chk_baud_fast: assert property (@(posedge clock) disable iff (!reset_n)
        testReg_q[BAUD_BIT] |=> baudTick)
        else $error("fast baud test not ticking");
    chk_cd_level: assert property (@(posedge clock) disable iff (!reset_n)
        statusRead && armed_q |=> regRdData[CD_LEVEL_BIT] == $past(handshakeIn.carrierDetect_n) ^ 1'b1)
        else $error("carrier level wrong");
    chk_ri_level: assert property (@(posedge clock) disable iff (!reset_n)
        statusRead && armed_q |=> regRdData[RI_LEVEL_BIT] != $past(handshakeIn.ringIndicator_n))
        else $error("ring level wrong");
    chk_dsr_level: assert property (@(posedge clock) disable iff (!reset_n)
        statusRead && armed_q |=> regRdData[DSR_LEVEL_BIT] != $past(handshakeIn.dataSetReady_n))
        else $error("data set ready level wrong");
    chk_cd_change: assert property (@(posedge clock) disable iff (!reset_n)
        cdEdge ##1 statusRead |=> regRdData[CD_CHANGE_BIT])
        else $error("carrier change lost");
    chk_ri_fall: assert property (@(posedge clock) disable iff (!reset_n)
        riFall && !riRise_q |=> !riRise_q)
        else $error("ring flag set on falling pin");
    chk_dsr_change: assert property (@(posedge clock) disable iff (!reset_n)
        dsrEdge |=> dsrChange_q && irqStatus_q[IRQ_DSR])
        else $error("dsr change lost");
    chk_read_clears: assert property (@(posedge clock) disable iff (!reset_n)
        statusRead && !cdEdge && !riEdge && !dsrEdge |=> !cdChange_q && !riRise_q && !dsrChange_q)
        else $error("change flags survive read");
    chk_irq_raise: assert property (@(posedge clock) disable iff (!reset_n)
        riEdge && irqMask_q[IRQ_RI] && !irqMaskWrite |=> irq)
        else $error("ring event gave no interrupt");
    chk_status_reset: assert property (@(posedge clock)
        !reset_n |-> !cdChange_q && !riRise_q && !dsrChange_q && regRdData == STATUS_RESET)
        else $error("status not zero in reset");

    // transmit fields pass untouched outside their test
    chk_parity_clean: assert property (@(posedge clock) disable iff (!reset_n)
        !(testReg_q[PARITY_BIT] && !fastInfraredMode) |=> txOut.parityBit == $past(txIn.parityBit))
        else $error("parity changed without test");
    // parity test has no effect in fast mode
    chk_parity_fast: assert property (@(posedge clock) disable iff (!reset_n)
        fastInfraredMode |=> txOut.parityBit == $past(txIn.parityBit))
        else $error("parity changed in fast mode");
    // crc only flipped under its test
    chk_crc_clean: assert property (@(posedge clock) disable iff (!reset_n)
        !(testReg_q[CRC_BIT] && fastInfraredMode) |=> txOut.crc == $past(txIn.crc))
        else $error("crc changed without test");
    // chip code only replaced under its test
    chk_chip_clean: assert property (@(posedge clock) disable iff (!reset_n)
        !(testReg_q[CHIP_BIT] && fastInfraredMode) |=> txOut.chipCode == $past(txIn.chipCode))
        else $error("chip changed without test");
    // stop bit stays high in fast mode
    chk_stop_fast: assert property (@(posedge clock) disable iff (!reset_n)
        fastInfraredMode |=> txOut.stopBit)
        else $error("stop bit low in fast mode");

    // normal divider holds the tick low mid count
    chk_baud_idle: assert property (@(posedge clock) disable iff (!reset_n)
        !testReg_q[BAUD_BIT] && baudCount_q + 1'b1 < baudDivisor |=> !baudTick)
        else $error("baud tick too early");
    // normal divider ticks and restarts at the end
    chk_baud_count: assert property (@(posedge clock) disable iff (!reset_n)
        !testReg_q[BAUD_BIT] && baudCount_q + 1'b1 >= baudDivisor |=> baudTick && baudCount_q == '0)
        else $error("baud tick missing");

    // flags set on their events
    chk_cd_set: assert property (@(posedge clock) disable iff (!reset_n)
        cdEdge |=> cdChange_q && irqStatus_q[IRQ_CD])
        else $error("carrier change not flagged");
    chk_ri_rise: assert property (@(posedge clock) disable iff (!reset_n)
        riEdge |=> riRise_q && irqStatus_q[IRQ_RI])
        else $error("ring rise not flagged");
    // flags stay until a status read
    chk_cd_hold: assert property (@(posedge clock) disable iff (!reset_n)
        cdChange_q && !statusRead |=> cdChange_q)
        else $error("carrier flag lost");
    chk_ri_hold: assert property (@(posedge clock) disable iff (!reset_n)
        riRise_q && !statusRead |=> riRise_q)
        else $error("ring flag lost");
    chk_dsr_hold: assert property (@(posedge clock) disable iff (!reset_n)
        dsrChange_q && !statusRead |=> dsrChange_q)
        else $error("dsr flag lost");
    // no flag without an event
    chk_no_false_cd: assert property (@(posedge clock) disable iff (!reset_n)
        !cdEdge && !cdChange_q |=> !cdChange_q)
        else $error("carrier flag without change");
    chk_no_false_dsr: assert property (@(posedge clock) disable iff (!reset_n)
        !dsrEdge && !dsrChange_q |=> !dsrChange_q)
        else $error("dsr flag without change");
    // falling ring pin raises no interrupt either
    chk_ri_fall_irq: assert property (@(posedge clock) disable iff (!reset_n)
        riFall && !irqStatus_q[IRQ_RI] |=> !irqStatus_q[IRQ_RI])
        else $error("ring fall set interrupt");
    // flags returned by the read
    chk_ri_read: assert property (@(posedge clock) disable iff (!reset_n)
        riEdge ##1 statusRead |=> regRdData[RI_RISE_BIT])
        else $error("ring flag not read");
    chk_dsr_read: assert property (@(posedge clock) disable iff (!reset_n)
        dsrEdge ##1 statusRead |=> regRdData[DSR_CHANGE_BIT])
        else $error("dsr flag not read");

    // each line reaches the interrupt pin
    chk_irq_cd: assert property (@(posedge clock) disable iff (!reset_n)
        cdEdge && irqMask_q[IRQ_CD] && !irqMaskWrite |=> irq)
        else $error("carrier event gave no interrupt");
    chk_irq_dsr: assert property (@(posedge clock) disable iff (!reset_n)
        dsrEdge && irqMask_q[IRQ_DSR] && !irqMaskWrite |=> irq)
        else $error("dsr event gave no interrupt");
    // sticky until written with a one
    chk_irq_sticky: assert property (@(posedge clock) disable iff (!reset_n)
        irqStatus_q[IRQ_CD] && !(irqStatusWrite && regReq.wrData[IRQ_CD]) |=> irqStatus_q[IRQ_CD])
        else $error("interrupt bit lost");
    chk_irq_clear: assert property (@(posedge clock) disable iff (!reset_n)
        irqStatusWrite && regReq.wrData[IRQ_RI] && !riEdge |=> !irqStatus_q[IRQ_RI])
        else $error("interrupt bit not cleared");
    chk_mask_write: assert property (@(posedge clock) disable iff (!reset_n)
        irqMaskWrite |=> irqMask_q == $past(regReq.wrData[2:0]))
        else $error("mask write lost");

    // read port behaviour
    chk_rd_idle: assert property (@(posedge clock) disable iff (!reset_n)
        !regReq.read |=> regRdData == READ_ZERO)
        else $error("read data without strobe");
    chk_test_wo: assert property (@(posedge clock) disable iff (!reset_n)
        regReq.read && regReq.addr == TEST_OFFSET |=> regRdData == READ_ZERO)
        else $error("test register readable");
    chk_unmapped: assert property (@(posedge clock) disable iff (!reset_n)
        regReq.read && regReq.addr != STATUS_OFFSET && regReq.addr != IRQ_STATUS_OFFSET
        && regReq.addr != IRQ_MASK_OFFSET |=> regRdData == READ_ZERO)
        else $error("unmapped read not zero");
    chk_irq_read: assert property (@(posedge clock) disable iff (!reset_n)
        regReq.read && regReq.addr == IRQ_STATUS_OFFSET |=> regRdData == {5'h00, $past(irqStatus_q)})
        else $error("interrupt status read wrong");
    // write lands in the test register
    chk_test_write: assert property (@(posedge clock) disable iff (!reset_n)
        testWrite |=> testReg_q == $past(regReq.wrData[TEST_USED-1:0]))
        else $error("test write lost");

    cov_cd_read: cover property (@(posedge clock) disable iff (!reset_n)
        cdEdge ##[1:20] statusRead);
    cov_ri_irq: cover property (@(posedge clock) disable iff (!reset_n)
        riEdge ##1 irq ##[1:20] irqStatusWrite);
    cov_edge_on_read: cover property (@(posedge clock) disable iff (!reset_n)
        statusRead && dsrEdge);
    cov_inject_all: cover property (@(posedge clock) disable iff (!reset_n)
        &testReg_q);
    cov_baud_fast: cover property (@(posedge clock) disable iff (!reset_n)
        testReg_q[BAUD_BIT] ##1 baudTick);
endmodule // uart_test_inject_modem_status

// ===== hdl/uart_tims_pkg.sv
// constants and carrier types for the test-inject and handshake status block
package uart_tims_pkg;
    // register offsets
    localparam logic [7:0] TEST_OFFSET = 8'h14;
    localparam logic [7:0] STATUS_OFFSET = 8'h18;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h1c;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h20;
    // values after reset
    localparam logic [7:0] TEST_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // test register fields
    localparam int CRC_BIT = 4;
    localparam int CHIP_BIT = 3;
    localparam int BAUD_BIT = 2;
    localparam int STOP_BIT = 1;
    localparam int PARITY_BIT = 0;
    localparam int TEST_USED = 5;
    // handshake status fields
    localparam int CD_LEVEL_BIT = 7;
    localparam int RI_LEVEL_BIT = 6;
    localparam int DSR_LEVEL_BIT = 5;
    localparam int CD_CHANGE_BIT = 3;
    localparam int RI_RISE_BIT = 2;
    localparam int DSR_CHANGE_BIT = 1;
    // interrupt status and mask fields
    localparam int IRQ_CD = 0;
    localparam int IRQ_RI = 1;
    localparam int IRQ_DSR = 2;
    // chip code sent when a corrupt chip is injected
    localparam logic [3:0] BAD_CHIP = 4'h0;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic write;
        logic read;
    } reg_req_t;

    typedef struct packed {
        logic carrierDetect_n;
        logic ringIndicator_n;
        logic dataSetReady_n;
    } handshake_in_t;

    typedef struct packed {
        logic parityBit;
        logic [3:0] chipCode;
        logic [15:0] crc;
    } tx_fields_t;

    typedef struct packed {
        logic parityBit;
        logic stopBit;
        logic [3:0] chipCode;
        logic [15:0] crc;
    } tx_line_t;
endpackage

// ===== sim/modem_line_model.sv
// behavioural far-side modem driving the active-low handshake lines
`timescale 1ns/1ps
module modem_line_model
    import uart_tims_pkg::*;
(
    input wire logic clock,
    output handshake_in_t lines
);
    // idle inactive (high): a fresh port sees no carrier, ring or ready
    initial lines = 3'b111;

    // levels change just after an edge, like a synchronous modem
    task automatic drive(input handshake_in_t v);
        @(posedge clock);
        lines <= v;
    endtask
endmodule // modem_line_model

// ===== sim/uart_test_inject_modem_status_tb.sv
// self-checking bench for the test-inject and handshake status block
`timescale 1ns/1ps
module uart_test_inject_modem_status_tb;
    import uart_tims_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b1;
    reg_req_t regReq = '0;
    logic [7:0] regRdData;
    handshake_in_t handshakeIn;
    logic fastInfraredMode = 1'b0;
    tx_fields_t txIn = '0;
    tx_line_t txOut;
    logic [15:0] baudDivisor = 16'h0004;
    logic baudTick;
    logic irq;
    int nFail = 0;
    int checkCount = 0;

    always #10 clock = ~clock;

    uart_test_inject_modem_status #(.DIV_WIDTH(16)) dut_u (.clock(clock), .reset_n(reset_n), .regReq(regReq),
        .regRdData(regRdData), .handshakeIn(handshakeIn), .fastInfraredMode(fastInfraredMode), .txIn(txIn),
        .txOut(txOut), .baudDivisor(baudDivisor), .baudTick(baudTick), .irq(irq));
    modem_line_model modem_u (.clock(clock), .lines(handshakeIn));

    task automatic chk(input string what, input logic [31:0] expV, input logic [31:0] got);
        checkCount++;
        if (got !== expV) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", what, expV, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regReq <= '{addr: a, wrData: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        regReq.write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] expV, input string what);
        @(posedge clock);
        regReq <= '{addr: a, wrData: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge clock);
        regReq.read <= 1'b0;
        #1;
        chk(what, 32'(expV), 32'(regRdData));
    endtask

    task automatic settle();
        repeat (3) @(posedge clock);
    endtask

    task automatic resetValues();
        rd(STATUS_OFFSET, STATUS_RESET, "status after reset");
        rd(TEST_OFFSET, READ_ZERO, "test register read");
        rd(8'h04, READ_ZERO, "unmapped read");
        wr(STATUS_OFFSET, 8'hff);
        rd(STATUS_OFFSET, STATUS_RESET, "status write ignored");
    endtask

    task automatic lineFlags();
        modem_u.drive(3'b011);
        settle();
        rd(STATUS_OFFSET, 8'h88, "carrier low");
        rd(STATUS_OFFSET, 8'h80, "carrier flag cleared");
        modem_u.drive(3'b010);
        settle();
        rd(STATUS_OFFSET, 8'ha2, "ready low");
        rd(STATUS_OFFSET, 8'ha0, "ready flag cleared");
        modem_u.drive(3'b000);
        settle();
        rd(STATUS_OFFSET, 8'he0, "ring pin falling");
        modem_u.drive(3'b010);
        settle();
        rd(STATUS_OFFSET, 8'ha4, "ring pin rising");
        rd(STATUS_OFFSET, 8'ha0, "ring flag cleared");
    endtask

    task automatic interrupts();
        wr(IRQ_STATUS_OFFSET, 8'h07);
        rd(IRQ_STATUS_OFFSET, 8'h00, "irq status cleared");
        modem_u.drive(3'b110);
        settle();
        chk("irq masked", 32'h0, 32'(irq));
        rd(IRQ_STATUS_OFFSET, 8'h01, "irq status carrier");
        wr(IRQ_MASK_OFFSET, 8'h01);
        #1;
        chk("irq unmasked", 32'h1, 32'(irq));
        rd(IRQ_MASK_OFFSET, 8'h01, "irq mask readback");
        wr(IRQ_STATUS_OFFSET, 8'h01);
        #1;
        chk("irq after clear", 32'h0, 32'(irq));
        wr(IRQ_MASK_OFFSET, 8'h07);
        modem_u.drive(3'b111);
        settle();
        chk("irq ready change", 32'h1, 32'(irq));
        rd(IRQ_STATUS_OFFSET, 8'h04, "irq status ready");
    endtask

    task automatic txCase(input logic [7:0] test, input logic mode, input tx_fields_t src, input tx_line_t expV,
        input string what);
        wr(TEST_OFFSET, test);
        fastInfraredMode <= mode;
        txIn <= src;
        @(posedge clock);
        #1;
        chk(what, 32'(expV), 32'(txOut));
    endtask

    task automatic baudCase(input logic [7:0] test, input logic [15:0] div, input int expTicks, input string what);
        int ticks = 0;
        baudDivisor <= div;
        wr(TEST_OFFSET, test);
        repeat (2) @(posedge clock);
        repeat (40) begin
            @(posedge clock);
            #1;
            if (baudTick === 1'b1) ticks++;
        end
        chk(what, 32'(expTicks), 32'(ticks));
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        reset_n <= 1'b0;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        resetValues();
        lineFlags();
        interrupts();
        txCase(8'h00, 1'b0, '{1'b1, 4'h5, 16'h1234}, '{1'b1, 1'b1, 4'h5, 16'h1234}, "tx clean");
        txCase(8'h01, 1'b0, '{1'b0, 4'h8, 16'h00ff}, '{1'b1, 1'b1, 4'h8, 16'h00ff}, "tx bad parity");
        txCase(8'h02, 1'b0, '{1'b1, 4'h5, 16'h1234}, '{1'b1, 1'b0, 4'h5, 16'h1234}, "tx zero stop");
        txCase(8'h03, 1'b1, '{1'b1, 4'h5, 16'h1234}, '{1'b1, 1'b1, 4'h5, 16'h1234}, "tx serial in fast");
        txCase(8'h10, 1'b1, '{1'b0, 4'h2, 16'hbeef}, '{1'b0, 1'b1, 4'h2, 16'h4110}, "tx bad crc");
        txCase(8'h08, 1'b1, '{1'b1, 4'h4, 16'ha5a5}, '{1'b1, 1'b1, BAD_CHIP, 16'ha5a5}, "tx bad chip");
        txCase(8'h18, 1'b0, '{1'b1, 4'h5, 16'h1234}, '{1'b1, 1'b1, 4'h5, 16'h1234}, "tx fast in serial");
        txCase(8'he0, 1'b0, '{1'b1, 4'h5, 16'h1234}, '{1'b1, 1'b1, 4'h5, 16'h1234}, "tx reserved bits");
        baudCase(8'h00, 16'h0004, 10, "ticks divisor four");
        baudCase(8'h00, 16'h0005, 8, "ticks divisor five");
        baudCase(8'h04, 16'h0005, 40, "ticks fast test");
        results();
    end

    // whole run is a few hundred cycles; this span only cuts a hang
    initial begin
        #100000;
        nFail++;
        results();
    end
endmodule // uart_test_inject_modem_status_tb
